// file: verilog/csg_pkg.sv
package csg_pkg;
  // Register byte offsets, one aligned 32-bit word each.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_QPOS = 8'h08;
  localparam logic [7:0] OFS_QCMP = 8'h0C;
  localparam logic [7:0] OFS_ECTL = 8'h10;
  localparam logic [7:0] OFS_E0PER = 8'h14;
  localparam logic [7:0] OFS_E0WID = 8'h18;
  localparam logic [7:0] OFS_E1PER = 8'h1C;
  localparam logic [7:0] OFS_E1WID = 8'h20;
  localparam logic [7:0] OFS_ROUTE = 8'h24;
  localparam logic [7:0] OFS_USER = 8'h28;
  localparam logic [7:0] OFS_HTIM = 8'h2C;
  localparam logic [7:0] OFS_VTIM = 8'h30;
  localparam logic [7:0] OFS_QSNAP = 8'h34;
  // Control register fields.
  localparam int CTRL_EN = 0;
  localparam int CTRL_ARST = 1;
  localparam int CTRL_SUB = 2;
  localparam int CTRL_POL = 4;
  localparam int CTRL_SRC = 5;
  localparam int CTRL_QTRG = 7;
  localparam int CTRL_FEN = 8;
  localparam int CTRL_FVAL = 9;
  localparam int CTRL_SOFT = 10;
  localparam int CTRL_STOP = 11;
  // Trigger sub-modes of the next-valid-frame mode.
  localparam logic [1:0] SUB_SINGLE = 2'h0;
  localparam logic [1:0] SUB_CONT = 2'h1;
  localparam logic [1:0] SUB_LEVEL = 2'h2;
  // Exposure control fields.
  localparam int ECTL_EN = 0;
  localparam int ECTL_EXT = 2;
  localparam int ECTL_TST = 4;
  localparam int ECTL_DIV = 8;
  localparam int ECTL_CDIV = 16;
  // Output route selector codes, three bits per output.
  localparam logic [2:0] SEL_USER = 3'h0;
  localparam logic [2:0] SEL_EXP = 3'h1;
  localparam logic [2:0] SEL_HS = 3'h5;
  localparam logic [2:0] SEL_VS = 3'h6;
  localparam logic [2:0] SEL_CLK = 3'h7;
  localparam int ROUTE_AUX = 12;
  // Bit positions in the synchronised input vector.
  localparam int SYN_W = 12;
  localparam int IX_TRIG = 0;
  localparam int IX_QA = 4;
  localparam int IX_QB = 5;
  localparam int IX_FLD = 6;
  localparam int IX_TCK = 7;
  localparam int IX_PCK = 8;
  localparam int IX_FV = 9;
  // Reset values.
  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] ECTL_RST = 32'h0001_0000;
  localparam logic [31:0] HTIM_RST = 32'h0010_03FF;
  localparam logic [31:0] VTIM_RST = 32'h0002_01FF;
  localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
  typedef struct packed {
    logic fval;
    logic lval;
    logic dval;
  } csg_link_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_WAIT, ST_GRAB} csg_state_t;
endpackage : csg_pkg

// file: verilog/csg_sync_generator.sv
// Contract
// - This generator serves its own acquisition path only, with no shared state.
// - Two path trigger pins plus two shared pins are selectable trigger sources.
// - Next-valid-frame mode waits for next valid frame or field before capture.
// - Edge single-shot captures exactly one frame per configured trigger edge.
// - Edge continuous starts capture on the edge and keeps capturing.
// - Level continuous captures while the trigger stays at its active level.
// - Software selects whether high or low trigger level counts as active.
// - Asynchronous reset mode restarts the source's frame on a trigger.
// - Two exposure timers, each making two periodic exposure outputs.
// - Each timer runs from an internal clock or the external timer clock.
// - Exposure outputs route to camera control lines or auxiliary outputs.
// - Four camera control outputs carry exposure, sync or user signals.
// - Auxiliary outputs carry exposure or user; aux inputs serve many roles.
// - The generator drives one horizontal and one vertical sync output.
// - A field polarity input identifies the current interlaced field.
// - A clock goes out to the source and a source clock is accepted.
// - Quadrature decoding updates a 16-bit position counter.
// - Position is readable during capture and can trigger a capture.
// - Decoding keeps up with encoder rates up to the pixel clock.
// - Two input pins carry the first and second quadrature code bits.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module csg_sync_generator
  import csg_pkg::*;
(
  input wire logic clk_i, // System clock, 100 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_we_i, // Write enable.
  input wire logic [7:0] wb_adr_i, // Byte address.
  input wire logic [3:0] wb_sel_i, // Byte selects.
  input wire logic [31:0] wb_dat_i, // Write data.
  output logic [31:0] wb_dat_o, // Read data.
  output logic wb_ack_o, // Acknowledge.
  input wire logic [3:0] trig_i, // Trigger pins, [1:0] own, [3:2] shared.
  input wire logic qa_i, // First quadrature code bit.
  input wire logic qb_i, // Second quadrature code bit.
  input wire logic field_i, // Field polarity pin.
  input wire logic tmr_clk_i, // External timer clock pin.
  input wire logic cam_clk_i, // Clock from the camera link.
  input wire csg_pkg::csg_link_t link_i, // Frame, line, data valid.
  output logic [3:0] cc_o, // Camera control lines 1 to 4.
  output logic [1:0] aux_o, // Auxiliary outputs.
  output logic hsync_o, // Horizontal sync to the source.
  output logic vsync_o, // Vertical sync to the source.
  output logic clk_out_o, // Clock to the source.
  output logic grab_o // High while a frame is captured.
);
  import csg_pkg::*;

  logic [SYN_W-1:0] raw;
  logic [SYN_W-1:0] s1_reg;
  logic [SYN_W-1:0] s2_reg;
  logic [SYN_W-1:0] s3_reg;
  logic [SYN_W-1:0] filt_reg;
  logic [SYN_W-1:0] filt_d_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] ectl_reg;
  logic [31:0] route_reg;
  logic [31:0] user_reg;
  logic [31:0] htim_reg;
  logic [31:0] vtim_reg;
  logic [31:0] eper_reg [2];
  logic [31:0] ewid_reg [2];
  logic [15:0] qpos_reg;
  logic [15:0] qcmp_reg;
  logic [15:0] qsnap_reg;
  logic qchg_reg;
  logic soft_reg;
  logic stop_reg;
  logic act_d_reg;
  logic [31:0] rdata;
  logic wr;
  logic rd_or_wr;
  logic [7:0] wadr;
  csg_state_t state_reg;
  csg_state_t state_next;
  logic act;
  logic trig_edge;
  logic qhit;
  logic fv_rise;
  logic fv_fall;
  logic field_ok;
  logic restart;
  logic [1:0] sub;
  logic [1:0] qdir;
  logic [15:0] hcnt_reg;
  logic [15:0] vcnt_reg;
  logic [7:0] cdiv_reg;
  logic ck_reg;
  logic [7:0] tdiv_reg;
  logic itick;
  logic [15:0] ecnt_reg [2];
  logic [3:0] exp_sig;
  logic hs;
  logic vs;

  // Merges the selected byte lanes of a write into the old value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Picks the signal that an output line carries.
  function automatic logic route(input logic [2:0] sel, input logic usr, input logic [3:0] ex,
                                 input logic h, input logic v, input logic c);
    logic r;
    r = usr;
    if (sel >= SEL_EXP && sel < SEL_HS)
    begin
      r = ex[2'(sel - SEL_EXP)];
    end
    else if (sel == SEL_HS)
    begin
      r = h;
    end
    else if (sel == SEL_VS)
    begin
      r = v;
    end
    else if (sel == SEL_CLK)
    begin
      r = c;
    end
    return r;
  endfunction : route

  // Gray step decode: bit 0 forward, bit 1 reverse, none on a skip.
  function automatic logic [1:0] qstep(input logic [1:0] p, input logic [1:0] c);
    logic [1:0] r;
    r = 2'h0;
    unique case ({p, c})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: r = 2'h1;
      4'b0100, 4'b1101, 4'b1011, 4'b0010: r = 2'h2;
      default: r = 2'h0;
    endcase
    return r;
  endfunction : qstep

  assign raw = {link_i.dval, link_i.lval, link_i.fval, cam_clk_i, tmr_clk_i, field_i, qb_i, qa_i, trig_i};

  // sync then filter
  // Two flops, then a bit only moves after two equal samples.
  // This swallows single-cycle glitches at the cost of two cycles of latency.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      filt_d_reg <= '0;
    end
    else
    begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
      filt_d_reg <= filt_reg;
    end
  end

  // Bus decode; every access is answered, unmapped ones read zero.
  assign rd_or_wr = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = rd_or_wr && wb_we_i;
  assign wadr = {wb_adr_i[7:2], 2'b00};

  // Acknowledge and read data one cycle after the strobe.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= rd_or_wr;
      wb_dat_o <= rd_or_wr ? rdata : 32'h0000_0000;
    end
  end

  // configuration registers
  // Configuration registers written by software.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg <= CTRL_RST;
      ectl_reg <= ECTL_RST;
      route_reg <= ROUTE_RST;
      user_reg <= '0;
      htim_reg <= HTIM_RST;
      vtim_reg <= VTIM_RST;
      qcmp_reg <= '0;
      for (int t = 0; t < 2; t++)
      begin
        eper_reg[t] <= '0;
        ewid_reg[t] <= '0;
      end
    end
    else if (wr)
    begin
      unique case (wadr)
        OFS_CTRL: ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_03FF;
        OFS_QCMP: qcmp_reg <= 16'(merge({16'h0000, qcmp_reg}, wb_dat_i, wb_sel_i));
        OFS_ECTL: ectl_reg <= merge(ectl_reg, wb_dat_i, wb_sel_i);
        OFS_E0PER: eper_reg[0] <= merge(eper_reg[0], wb_dat_i, wb_sel_i);
        OFS_E0WID: ewid_reg[0] <= merge(ewid_reg[0], wb_dat_i, wb_sel_i);
        OFS_E1PER: eper_reg[1] <= merge(eper_reg[1], wb_dat_i, wb_sel_i);
        OFS_E1WID: ewid_reg[1] <= merge(ewid_reg[1], wb_dat_i, wb_sel_i);
        OFS_ROUTE: route_reg <= merge(route_reg, wb_dat_i, wb_sel_i);
        OFS_USER: user_reg <= merge(user_reg, wb_dat_i, wb_sel_i);
        OFS_HTIM: htim_reg <= merge(htim_reg, wb_dat_i, wb_sel_i);
        OFS_VTIM: vtim_reg <= merge(vtim_reg, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Soft trigger and stop are one-cycle pulses; they read back as zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      soft_reg <= 1'b0;
      stop_reg <= 1'b0;
    end
    else
    begin
      soft_reg <= wr && wadr == OFS_CTRL && wb_sel_i[1] && wb_dat_i[CTRL_SOFT];
      stop_reg <= wr && wadr == OFS_CTRL && wb_sel_i[1] && wb_dat_i[CTRL_STOP];
    end
  end

  // Read multiplexer.
  always_comb
  begin
    rdata = 32'h0000_0000;
    unique case (wadr)
      OFS_CTRL: rdata = ctrl_reg;
      OFS_STAT: rdata = {17'h00000, filt_reg[IX_TCK], filt_reg[IX_QB], filt_reg[IX_QA],
                         filt_reg[IX_TRIG +: 4], 2'h0, act, filt_reg[IX_FV], filt_reg[IX_FLD],
                         state_reg == ST_ARM, state_reg == ST_WAIT, grab_o};
      OFS_QPOS: rdata = {16'h0000, qpos_reg};
      OFS_QCMP: rdata = {16'h0000, qcmp_reg};
      OFS_ECTL: rdata = ectl_reg;
      OFS_E0PER: rdata = eper_reg[0];
      OFS_E0WID: rdata = ewid_reg[0];
      OFS_E1PER: rdata = eper_reg[1];
      OFS_E1WID: rdata = ewid_reg[1];
      OFS_ROUTE: rdata = route_reg;
      OFS_USER: rdata = user_reg;
      OFS_HTIM: rdata = htim_reg;
      OFS_VTIM: rdata = vtim_reg;
      OFS_QSNAP: rdata = {16'h0000, qsnap_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end

  assign qdir = qstep({filt_d_reg[IX_QA], filt_d_reg[IX_QB]}, {filt_reg[IX_QA], filt_reg[IX_QB]});

  // per-cycle decode
  // Sampling at the system clock keeps up with code steps up to one per system cycle, as each code bit then holds two cycles, so the filter passes them.
  // A bus write to the position wins over a step in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      qpos_reg <= '0;
      qchg_reg <= 1'b0;
    end
    else
    begin
      qchg_reg <= qdir != 2'h0;
      if (wr && wadr == OFS_QPOS)
      begin
        qpos_reg <= 16'(merge({16'h0000, qpos_reg}, wb_dat_i, wb_sel_i));
      end
      else if (qdir[0])
      begin
        qpos_reg <= qpos_reg + 16'h0001;
      end
      else if (qdir[1])
      begin
        qpos_reg <= qpos_reg - 16'h0001;
      end
    end
  end

  assign qhit = qchg_reg && qpos_reg == qcmp_reg;

  assign act = filt_reg[IX_TRIG + int'(ctrl_reg[CTRL_SRC +: 2])] == ctrl_reg[CTRL_POL];
  assign trig_edge = (act && !act_d_reg) || soft_reg || (ctrl_reg[CTRL_QTRG] && qhit);
  assign sub = ctrl_reg[CTRL_SUB +: 2];
  assign fv_rise = filt_reg[IX_FV] && !filt_d_reg[IX_FV];
  assign fv_fall = !filt_reg[IX_FV] && filt_d_reg[IX_FV];
  assign field_ok = !ctrl_reg[CTRL_FEN] || filt_reg[IX_FLD] == ctrl_reg[CTRL_FVAL];
  assign restart = state_reg == ST_ARM && ctrl_reg[CTRL_ARST] && trig_edge;

  // Previous active level for edge detection.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      act_d_reg <= 1'b0;
    end
    else
    begin
      act_d_reg <= act;
    end
  end

  // Capture sequencer.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        state_next = ST_ARM;
      end
      ST_ARM:
      begin
        if ((sub == SUB_LEVEL && !ctrl_reg[CTRL_ARST]) ? act : trig_edge)
        begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (sub == SUB_LEVEL && !ctrl_reg[CTRL_ARST] && !act)
        begin
          state_next = ST_ARM;
        end
        else if (fv_rise && field_ok)
        begin
          state_next = ST_GRAB;
        end
      end
      ST_GRAB:
      begin
        if (fv_fall)
        begin
          if (ctrl_reg[CTRL_ARST] || sub == SUB_SINGLE)
          begin
            state_next = ST_ARM;
          end
          else if (sub == SUB_LEVEL && !act)
          begin
            state_next = ST_ARM;
          end
          else
          begin
            state_next = ST_WAIT;
          end
        end
      end
    endcase
    if (!ctrl_reg[CTRL_EN] || stop_reg)
    begin
      state_next = ST_IDLE;
    end
  end

  // path-local state
  // State, capture flag and the position snapshot at capture start.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      grab_o <= 1'b0;
      qsnap_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      grab_o <= state_next == ST_GRAB;
      if (state_reg == ST_WAIT && state_next == ST_GRAB)
      begin
        qsnap_reg <= qpos_reg;
      end
    end
  end

  // sync counters
  // A restart forces both counters to zero so a fresh vertical pulse starts.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart)
    begin
      hcnt_reg <= '0;
      vcnt_reg <= '0;
    end
    else if (hcnt_reg >= htim_reg[15:0])
    begin
      hcnt_reg <= '0;
      vcnt_reg <= (vcnt_reg >= vtim_reg[15:0]) ? 16'h0000 : vcnt_reg + 16'h0001;
    end
    else
    begin
      hcnt_reg <= hcnt_reg + 16'h0001;
    end
  end

  assign hs = hcnt_reg < htim_reg[31:16];
  assign vs = vcnt_reg < vtim_reg[31:16];

  // clock to source
  // Half period is the divider plus one system cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cdiv_reg <= '0;
      ck_reg <= 1'b0;
    end
    else if (cdiv_reg >= ectl_reg[ECTL_CDIV +: 8])
    begin
      cdiv_reg <= '0;
      ck_reg <= !ck_reg;
    end
    else
    begin
      cdiv_reg <= cdiv_reg + 8'h01;
    end
  end

  // Internal timer clock: one tick every divider plus one cycles.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tdiv_reg >= ectl_reg[ECTL_DIV +: 8])
    begin
      tdiv_reg <= '0;
    end
    else
    begin
      tdiv_reg <= tdiv_reg + 8'h01;
    end
  end

  assign itick = tdiv_reg >= ectl_reg[ECTL_DIV +: 8];

  // two exposure timers
  // In trigger-start mode a timer parks at its period until a trigger.
  // Widths are expected not to exceed the period.
  always_ff @(posedge clk_i)
  begin
    for (int t = 0; t < 2; t++)
    begin
      if (rst_i || !ectl_reg[ECTL_EN + t])
      begin
        ecnt_reg[t] <= '0;
      end
      else if (ectl_reg[ECTL_TST + t] && trig_edge)
      begin
        ecnt_reg[t] <= '0;
      end
      else if (ectl_reg[ECTL_EXT + t] ? (filt_reg[IX_TCK] && !filt_d_reg[IX_TCK]) : itick)
      begin
        if (ecnt_reg[t] < eper_reg[t][15:0])
        begin
          ecnt_reg[t] <= ecnt_reg[t] + 16'h0001;
        end
        else if (!ectl_reg[ECTL_TST + t])
        begin
          ecnt_reg[t] <= '0;
        end
      end
    end
  end

  // Two exposure signals per timer, each with its own width.
  always_comb
  begin
    for (int t = 0; t < 2; t++)
    begin
      exp_sig[2*t] = ectl_reg[ECTL_EN + t] && ecnt_reg[t] < ewid_reg[t][15:0];
      exp_sig[2*t+1] = ectl_reg[ECTL_EN + t] && ecnt_reg[t] < ewid_reg[t][31:16];
    end
  end

  // routed and sync outputs
  // Auxiliary outputs may only carry exposure or user levels.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cc_o <= '0;
      aux_o <= '0;
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      clk_out_o <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        cc_o[i] <= route(route_reg[3*i +: 3], user_reg[i], exp_sig, hs, vs, ck_reg);
      end
      for (int i = 0; i < 2; i++)
      begin
        aux_o[i] <= route(route_reg[ROUTE_AUX + 3*i +: 3] > 3'h4 ? SEL_USER :
                          route_reg[ROUTE_AUX + 3*i +: 3], user_reg[4+i], exp_sig, 1'b0, 1'b0, 1'b0);
      end
      hsync_o <= hs;
      vsync_o <= vs;
      clk_out_o <= ck_reg;
    end
  end

endmodule : csg_sync_generator

// file: tb/csg_sync_generator_monitor.sv
`timescale 1ns/1ps
module csg_sync_generator_monitor (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire csg_pkg::csg_link_t link_i, // Link valids.
  input wire logic [3:0] cc_o, // Control lines.
  input wire logic [1:0] aux_o, // Aux outputs.
  input wire logic clk_out_o, // Clock out.
  input wire logic grab_o // Capture flag.
);
  import csg_pkg::*;
  // All checks run on the system clock; all but the reset check pause in reset.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");
  // reset quiets outputs; this one must also run while reset is high.
  property p_rst_quiet;
    disable iff (1'h0) rst_i |=> !wb_ack_o && !grab_o && !clk_out_o && cc_o == 4'h0 && aux_o == 2'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy in reset");
  // no capture straight out of reset, the filter alone takes longer.
  property p_post_rst;
    $fell(rst_i) |-> !grab_o [*4];
  endproperty
  a_post_rst: assert property (p_post_rst) else $error("capture after reset");
  property p_grab_frame;
    $rose(grab_o) |-> link_i.fval && $past(link_i.fval, 4);
  endproperty
  a_grab_frame: assert property (p_grab_frame) else $error("capture outside frame");
  property p_grab_end;
    $fell(link_i.fval) ##1 !link_i.fval [*3] |-> ##[1:6] !grab_o;
  endproperty
  a_grab_end: assert property (p_grab_end) else $error("capture past frame end");
endmodule : csg_sync_generator_monitor

bind csg_sync_generator csg_sync_generator_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .link_i, .cc_o, .aux_o, .clk_out_o, .grab_o);

// file: tb/csg_camera_model.sv
`timescale 1ns/1ps
module csg_camera_model (
  input wire logic run_i, // Stream frames.
  output logic cam_clk_o, // Link clock.
  output csg_pkg::csg_link_t link_o // Link valids.
);
  import csg_pkg::*;
  // frames of eight link clocks; the clock stands still in the gap.
  initial
  begin
    cam_clk_o = 1'h0;
    link_o = '0;
    // Start a few ns off the bench clock's edges so that no pin moves on a sampling edge.
    wait (run_i === 1'h1);
    #3;
    forever
    begin
      wait (run_i === 1'h1);
      link_o.fval = 1'h1;
      repeat (8)
      begin
        #80 cam_clk_o = 1'h1;
        link_o.lval = ~link_o.lval;
        link_o.dval = link_o.lval;
        #80 cam_clk_o = 1'h0;
      end
      link_o = '0;
      #640;
    end
  end
endmodule : csg_camera_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import csg_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] trig_i = 4'h0;
  logic qa_i = 1'h0;
  logic qb_i = 1'h0;
  logic field_i = 1'h0;
  logic tmr_clk_i = 1'h0;
  logic run = 1'h0;
  logic cam_clk_i, wb_ack_o, hsync_o, vsync_o, clk_out_o, grab_o, grab_q;
  logic [31:0] wb_dat_o, rd;
  logic [3:0] cc_o;
  logic [1:0] aux_o;
  logic [8:0] mon;
  csg_link_t link_i;
  int fail_count = 0;
  int checks_done = 0;
  int grab_n = 0;
  int n0, c, c2;
  logic [7:0] ra [7] = '{OFS_CTRL, OFS_ECTL, OFS_HTIM, OFS_VTIM, OFS_ROUTE, OFS_QPOS, 8'h3C};
  logic [31:0] rv [7] = '{CTRL_RST, ECTL_RST, HTIM_RST, VTIM_RST, ROUTE_RST, 32'h0, 32'h0};

  csg_sync_generator DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .trig_i, .qa_i, .qb_i, .field_i, .tmr_clk_i, .cam_clk_i, .link_i, .cc_o, .aux_o,
    .hsync_o, .vsync_o, .clk_out_o, .grab_o);
  csg_camera_model u_cam (.run_i(run), .cam_clk_o(cam_clk_i), .link_o(link_i));

  // Output probe: [0] vsync, [1] hsync, [5:2] control lines, [7:6] aux, [8] clock out.
  assign mon = {clk_out_o, aux_o, cc_o, hsync_o, vsync_o};

  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // Counts captured frames by rising edges of the capture flag.
  always @(posedge clk_i)
  begin
    if (grab_o === 1'h1 && grab_q !== 1'h1)
      grab_n <= grab_n + 1;
    grab_q <= grab_o;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Single bus cycle, held until ack is sampled, so no wait length is assumed.
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  function automatic logic [31:0] mk(input logic [1:0] s, input logic p, input logic [1:0] src);
    return (32'h1 << CTRL_EN) | (32'(p) << CTRL_POL) | (32'(s) << CTRL_SUB) | (32'(src) << CTRL_SRC);
  endfunction : mk

  task automatic pulse(input int i, input logic lvl, input int w);
    @(posedge clk_i);
    trig_i[i] <= lvl;
    repeat (w) @(posedge clk_i);
    trig_i[i] <= ~lvl;
  endtask : pulse

  // one Gray code step, held long enough to pass the input filter.
  task automatic qstep(input logic [1:0] code);
    @(posedge clk_i);
    {qa_i, qb_i} <= code;
    repeat (8) @(posedge clk_i);
  endtask : qstep

  task automatic hi_cnt(input int b, input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      k += (mon[b] === 1'h1);
    end
  endtask : hi_cnt

  // Arms a trigger mode, fires one pulse and counts frames over about five frame times.
  task automatic grabs(input logic [31:0] cfg, input int i, input logic lvl, input int w, output int d);
    @(posedge clk_i);
    trig_i[i] <= ~lvl;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, cfg);
    n0 = grab_n;
    pulse(i, lvl, w);
    repeat (900) @(posedge clk_i);
    d = grab_n - n0;
  endtask : grabs

  task automatic end_of_test;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Watchdog well beyond the roughly 6500 cycles the tests need.
  initial
  begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    run <= 1'h1;
    for (int k = 0; k < 7; k++)
      rdc(ra[k], rv[k]);
    wr(8'h3C, 32'hFFFF_FFFF);
    wr(OFS_QSNAP, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h0);
    rdc(OFS_QSNAP, 32'h0);
    wr(OFS_QPOS, 32'h0000_FFFF);
    qstep(2'h1);
    rdc(OFS_QPOS, 32'h0);
    qstep(2'h3);
    qstep(2'h2);
    qstep(2'h3);
    qstep(2'h0);
    rdc(OFS_QPOS, 32'h1);
    grabs(mk(SUB_SINGLE, 1'h1, 2'h0), 0, 1'h1, 1, c);
    chk(c, 0);
    grabs(mk(SUB_SINGLE, 1'h1, 2'h0), 0, 1'h1, 40, c);
    chk(c, 1);
    grabs(mk(SUB_CONT, 1'h0, 2'h3), 3, 1'h0, 40, c);
    chk(c > 1, 1);
    grabs(mk(SUB_LEVEL, 1'h0, 2'h1), 1, 1'h0, 1000, c);
    chk(c > 1, 1);
    n0 = grab_n;
    repeat (600) @(posedge clk_i);
    chk(grab_n - n0, 0);
    field_i <= 1'h1;
    wr(OFS_QCMP, 32'h2);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, mk(SUB_SINGLE, 1'h1, 2'h0) | (32'h1 << CTRL_QTRG) | (32'h3 << CTRL_FEN));
    n0 = grab_n;
    qstep(2'h1);
    repeat (450) @(posedge clk_i);
    chk(grab_n - n0, 1);
    rdc(OFS_QSNAP, 32'h2);
    wr(OFS_HTIM, 32'h0002_000F);
    wr(OFS_VTIM, 32'h0001_00FF);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, mk(SUB_SINGLE, 1'h1, 2'h0) | (32'h1 << CTRL_ARST));
    fork
      pulse(0, 1'h1, 40);
      hi_cnt(0, 30, c);
    join
    chk(c, 16);
    hi_cnt(1, 32, c);
    chk(c, 4);
    wr(OFS_USER, 32'h3F);
    wr(OFS_ROUTE, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(32'({aux_o, cc_o}), 32'h3F);
    wr(OFS_E0PER, 32'h9);
    wr(OFS_E0WID, 32'h0005_0003);
    wr(OFS_ECTL, 32'h0001_0001);
    wr(OFS_ROUTE, 32'(SEL_HS) | (32'(SEL_CLK) << 3) | (32'(SEL_EXP) << 9) | (32'(SEL_EXP) << ROUTE_AUX));
    hi_cnt(2, 32, c);
    chk(c, 4);
    hi_cnt(3, 32, c);
    chk(c, 16);
    hi_cnt(8, 32, c);
    chk(c, 16);
    fork
      hi_cnt(5, 100, c);
      hi_cnt(6, 100, c2);
    join
    chk(c, c2);
    chk(c > 15 && c < 45, 1);
    wr(OFS_ECTL, 32'h0001_0005);
    hi_cnt(6, 100, c);
    chk(c % 100, 0);
    fork
      repeat (50)
      begin
        repeat (4) @(posedge clk_i);
        tmr_clk_i <= ~tmr_clk_i;
      end
      hi_cnt(6, 200, c);
    join
    chk(c > 0 && c < 200, 1);
    end_of_test();
  end
endmodule : testbench
